/* rtl/tmr_defs.vh */
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// Register indices; byte address is four times the index
`define TMR_IDX_CLKSEL 16'hff41
`define TMR_IDX_CMP_A 16'hff42
`define TMR_IDX_CMP_B 16'hff43
`define TMR_IDX_CNT_A 16'hff44
`define TMR_IDX_CNT_B 16'hff45
`define TMR_IDX_MODE 16'hff46
`define TMR_IDX_CNT16 16'hff47
`define TMR_IDX_BITOP 16'hff48
`define TMR_IDX_OSC 16'hff49

// Mode control fields
`define TMR_RUN_A 0
`define TMR_RUN_B 1
`define TMR_CASCADE 2
// Bit operation fields
`define TMR_BITOP_POS 2:0
`define TMR_BITOP_VAL 3
// Oscillator mode field
`define TMR_OSC_FAST 0
// Clock select nibbles
`define TMR_SEL_A 3:0
`define TMR_SEL_B 7:4

// Clock select codes
`define TMR_SEL_FALL 4'h0
`define TMR_SEL_RISE 4'h1
`define TMR_SEL_DIV_LO 4'h6
`define TMR_SEL_DIV_HI 4'he
`define TMR_SEL_DIV_TOP 4'hf
`define TMR_EXP_OFS 4'h5
`define TMR_EXP_TOP 4'hb

`define TMR_BYTE_ZERO 8'h00
`define TMR_BYTE_MAX 8'hff
`define TMR_REG_RST 8'h00
`define TMR_RESP_OKAY 2'b00
`define TMR_RESP_SLVERR 2'b10

`endif

/* rtl/tmr_edge_sync.v */
`timescale 1ns/1ps
`include "tmr_defs.vh"

module tmr_edge_sync (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire pin_in, // Asynchronous count pin
	output reg rise, // One-cycle pulse on a rising edge
	output reg fall // One-cycle pulse on a falling edge
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg level_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			rise <= 1'b0;
			fall <= 1'b0;
			// Change accepted only once two stages agree
			if (s2_r == s3_r && s3_r != level_r) begin
				level_r <= s3_r;
				rise <= s3_r; // RULE23
				fall <= ~s3_r; // RULE23
			end
		end
	end
endmodule

/* rtl/tmr_src_sel.v */
`timescale 1ns/1ps
`include "tmr_defs.vh"

module tmr_src_sel #(
	parameter PRE_W = 13
) (
	input wire [3:0] sel, // Clock select nibble
	input wire osc_fast, // 1: prescaler runs at full rate
	input wire [PRE_W-1:0] pre, // Free-running prescaler
	input wire ext_rise, // Synchronised rising edge
	input wire ext_fall, // Synchronised falling edge
	output reg tick // One count clock this cycle
);
	reg [3:0] exp_w;
	reg [PRE_W-1:0] mask;

	always @* begin
		exp_w = 4'h0;
		mask = {PRE_W{1'b0}};
		tick = 1'b0;
		case (sel)
			`TMR_SEL_FALL: tick = ext_fall; // RULE12
			`TMR_SEL_RISE: tick = ext_rise; // RULE12
			default: begin
				if (sel >= `TMR_SEL_DIV_LO) begin
					exp_w = (sel == `TMR_SEL_DIV_TOP) ? `TMR_EXP_TOP : sel - `TMR_EXP_OFS; // RULE12
					// Slow oscillator mode doubles every period
					exp_w = exp_w + {3'b000, ~osc_fast}; // RULE13
					mask = ~({PRE_W{1'b1}} << exp_w);
					tick = &(pre | ~mask);
				end
				// Prohibited codes produce no count clock
			end
		endcase
	end
endmodule

/* rtl/tmr_dual_timer.v */
// How it works
// RULE1: each 8-bit counter is compared with its compare byte; equality raises its request.
// RULE2: interval mode: on match the counter clears to zero, keeps counting, raises request.
// RULE3: compare bytes take 00h to ffh; paired they give 0000h to ffffh.
// RULE4: software writes compare bytes singly; no 16-bit writes to them.
// RULE5: reset clears both counts to 00h; compare bytes are left undefined.
// RULE6: reset clears clock select and mode control to 00h.
// RULE7: in 16-bit mode software stops counting before new compare values.
// RULE8: compare below count gives no clear; counter wraps through zero first.
// RULE9: software restarts the timer after lowering a compare value.
// RULE10: counts read as bytes; in 16-bit mode one read returns both consistently.
// RULE11: low clock select nibble feeds channel A, high nibble channel B.
// RULE12: codes: 0 falling pin, 1 rising pin, 6..e divide 2..512, f divide 2048.
// RULE13: prescaler runs at oscillator rate or half, per the oscillator mode bit.
// RULE14: software stops the timer before changing clock select.
// RULE15: mode control holds run bits of both channels and channel B mode.
// RULE16: mode control takes whole-byte writes and single-bit writes.
// RULE17: software stops counting before switching between 8-bit and 16-bit mode.
// RULE18: in 16-bit mode software starts and stops with the joint enable only.
// RULE19: mode bit 2 selects cascade; channel A then uses its own nibble.
// RULE20: in cascade, counter A overflow clocks counter B.
// RULE21: in cascade, compare B is the high byte and compare A the low byte.
// RULE22: in cascade, only a double match clears both and raises channel B request.
// RULE23: pin inputs are synchronised; each qualifying edge counts exactly once.
// RULE24: a stopped channel holds zero, ignores clocks and raises no request.
`timescale 1ns/1ps
`include "tmr_defs.vh"

module tmr_dual_timer #(
	parameter ADDR_W = 18,
	parameter PRE_W = 13
) (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write byte strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire ext_count_in_a, // Event pin, channel A
	input wire ext_count_in_b, // Event pin, channel B
	output reg match_irq_a, // Match pulse, channel A
	output reg match_irq_b // Match pulse, channel B
);
	reg [7:0] count_clock_select_r;
	reg [7:0] compare_value_a_r;
	reg [7:0] compare_value_b_r;
	reg [7:0] count_value_a_r;
	reg [7:0] count_value_b_r;
	reg [7:0] timer_mode_control_r;
	reg osc_mode_select_r;
	reg [PRE_W-1:0] pre_r;

	reg aw_hold_r;
	reg [ADDR_W-1:0] aw_addr_r;
	reg w_hold_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	wire rise_a;
	wire fall_a;
	wire rise_b;
	wire fall_b;
	wire src_tick_a;
	wire src_tick_b;

	wire [15:0] wr_idx = aw_addr_r[ADDR_W-1:2];
	wire [15:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
	wire [7:0] wr_byte = w_data_r[7:0];
	wire wr_lane0 = w_strb_r[0];
	wire do_wr = aw_hold_r & w_hold_r;

	wire run_a = timer_mode_control_r[`TMR_RUN_A];
	wire cascade = timer_mode_control_r[`TMR_CASCADE]; // RULE19
	// Joint enable drives both halves in cascade
	wire run_b = cascade ? run_a : timer_mode_control_r[`TMR_RUN_B]; // RULE15 RULE18
	wire match_a = count_value_a_r == compare_value_a_r; // RULE1
	wire match_b = count_value_b_r == compare_value_b_r; // RULE1 RULE21
	wire tick_a = run_a & src_tick_a; // RULE24
	wire ovf_a = tick_a & (count_value_a_r == `TMR_BYTE_MAX);
	wire match16 = tick_a & match_a & match_b; // RULE22
	wire tick_b = run_b & (cascade ? ovf_a : src_tick_b); // RULE20

	assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	tmr_edge_sync u_sync_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(ext_count_in_a),
		.rise(rise_a),
		.fall(fall_a)
	);

	tmr_edge_sync u_sync_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(ext_count_in_b),
		.rise(rise_b),
		.fall(fall_b)
	);

	tmr_src_sel #(.PRE_W(PRE_W)) u_sel_a (
		.sel(count_clock_select_r[`TMR_SEL_A]), // RULE11 RULE19
		.osc_fast(osc_mode_select_r),
		.pre(pre_r),
		.ext_rise(rise_a),
		.ext_fall(fall_a),
		.tick(src_tick_a)
	);

	tmr_src_sel #(.PRE_W(PRE_W)) u_sel_b (
		.sel(count_clock_select_r[`TMR_SEL_B]), // RULE11
		.osc_fast(osc_mode_select_r),
		.pre(pre_r),
		.ext_rise(rise_b),
		.ext_fall(fall_b),
		.tick(src_tick_b)
	);

	// Address decode for both directions
	function mapped;
		input [15:0] idx;
		begin
			mapped = (idx >= `TMR_IDX_CLKSEL) && (idx <= `TMR_IDX_OSC);
		end
	endfunction

	// Write channel: address and data accepted in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= {ADDR_W{1'b0}};
			w_hold_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TMR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wr_idx) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_clock_select_r <= `TMR_REG_RST; // RULE6
			timer_mode_control_r <= `TMR_REG_RST; // RULE6
			osc_mode_select_r <= 1'b0;
		end else if (do_wr && wr_lane0) begin
			case (wr_idx)
				`TMR_IDX_CLKSEL: count_clock_select_r <= wr_byte;
				`TMR_IDX_MODE: timer_mode_control_r <= wr_byte; // RULE16
				`TMR_IDX_BITOP: begin
					// Only the addressed bit moves
					timer_mode_control_r[wr_byte[`TMR_BITOP_POS]] <=
						wr_byte[`TMR_BITOP_VAL]; // RULE16
				end
				`TMR_IDX_OSC: osc_mode_select_r <= wr_byte[`TMR_OSC_FAST];
				default: begin
				end
			endcase
		end
	end

	// Compare bytes carry no reset; software must load them before starting
	always @(posedge aclk) begin
		if (do_wr && wr_lane0 && wr_idx == `TMR_IDX_CMP_A) begin
			compare_value_a_r <= wr_byte; // RULE3 RULE4 RULE5
		end
		if (do_wr && wr_lane0 && wr_idx == `TMR_IDX_CMP_B) begin
			compare_value_b_r <= wr_byte; // RULE3 RULE4 RULE5
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_r <= {PRE_W{1'b0}};
		end else begin
			pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
		end
	end

	// Counters and match requests
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_value_a_r <= `TMR_BYTE_ZERO; // RULE5
			count_value_b_r <= `TMR_BYTE_ZERO; // RULE5
			match_irq_a <= 1'b0;
			match_irq_b <= 1'b0;
		end else begin
			// Channel A still flags its own match in cascade
			match_irq_a <= tick_a & match_a; // RULE1 RULE2
			match_irq_b <= cascade ? (run_b & match16) : (tick_b & match_b); // RULE22 RULE24
			if (!run_a) begin
				count_value_a_r <= `TMR_BYTE_ZERO; // RULE24
			end else if (tick_a) begin
				if (match_a && (!cascade || match_b)) begin
					count_value_a_r <= `TMR_BYTE_ZERO; // RULE2 RULE22
				end else begin
					// No match below the count: runs on and wraps
					count_value_a_r <= count_value_a_r + 8'h01; // RULE8
				end
			end
			if (!run_b) begin
				count_value_b_r <= `TMR_BYTE_ZERO; // RULE24
			end else if (cascade && match16) begin
				count_value_b_r <= `TMR_BYTE_ZERO; // RULE22
			end else if (tick_b) begin
				if (!cascade && match_b) begin
					count_value_b_r <= `TMR_BYTE_ZERO; // RULE2
				end else begin
					count_value_b_r <= count_value_b_r + 8'h01; // RULE8 RULE20
				end
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TMR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(rd_idx) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
			case (rd_idx)
				`TMR_IDX_CLKSEL: s_axi_rdata <= {24'h000000, count_clock_select_r};
				`TMR_IDX_CMP_A: s_axi_rdata <= {24'h000000, compare_value_a_r};
				`TMR_IDX_CMP_B: s_axi_rdata <= {24'h000000, compare_value_b_r};
				`TMR_IDX_CNT_A: s_axi_rdata <= {24'h000000, count_value_a_r}; // RULE10
				`TMR_IDX_CNT_B: s_axi_rdata <= {24'h000000, count_value_b_r}; // RULE10
				`TMR_IDX_MODE: s_axi_rdata <= {24'h000000, timer_mode_control_r};
				// Both bytes sampled on the same edge, so never torn
				`TMR_IDX_CNT16: s_axi_rdata <= {16'h0000, count_value_b_r, count_value_a_r}; // RULE10
				`TMR_IDX_OSC: s_axi_rdata <= {31'h00000000, osc_mode_select_r};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* test/tmr_dual_timer_checker.sv */
`timescale 1ns/1ps
module tmr_dual_timer_checker (
	input wire aclk, // Clock
	input wire aresetn, // Reset
	input wire s_axi_awvalid, // In
	input wire s_axi_awready, // In
	input wire s_axi_wvalid, // In
	input wire s_axi_wready, // In
	input wire s_axi_bvalid, // In
	input wire s_axi_bready, // In
	input wire s_axi_arvalid, // In
	input wire s_axi_arready, // In
	input wire s_axi_rvalid, // In
	input wire s_axi_rready, // In
	input wire match_irq_a, // In
	input wire match_irq_b // In
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_irq_a; match_irq_a |=> !match_irq_a; endproperty
	property p_irq_b; match_irq_b |=> !match_irq_b; endproperty
	property p_wr; s_wr |-> ##2 s_axi_bvalid; endproperty
	property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_b_busy; s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready; endproperty
	property p_rd; s_rd |=> s_axi_rvalid; endproperty
	property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_irq_a: assert property (p_irq_a) else $error("irq a wider than one cycle");
	a_irq_b: assert property (p_irq_b) else $error("irq b wider than one cycle");
	a_wr: assert property (p_wr) else $error("write response late");
	a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
	a_b_busy: assert property (p_b_busy) else $error("write channel not reopened");
	a_rd: assert property (p_rd) else $error("read data late");
	a_r_busy: assert property (p_r_busy) else $error("read taken during response");
	a_r_drop: assert property (p_r_drop) else $error("rvalid stuck");
endmodule
bind tmr_dual_timer tmr_dual_timer_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .match_irq_a(match_irq_a),
	.match_irq_b(match_irq_b));

/* test/tmr_dual_timer_bench.sv */
`timescale 1ns/1ps
`include "tmr_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tmr_dual_timer_bench;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, pa = 0, pb = 0;
	logic [17:0] awaddr = 0, araddr = 0;
	logic [31:0] rv;
	logic [1:0] rs;
	wire awready, wready, bvalid, arready, rvalid, irq_a, irq_b;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	logic [7:0] wd = 0;
	logic [3:0] ws = 4'h1;
	int fail_count = 0, tests_run = 0, gap, c;
	tmr_dual_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata({24'h0, wd}),
		.s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.ext_count_in_a(pa), .ext_count_in_b(pb), .match_irq_a(irq_a), .match_irq_b(irq_b));
	initial forever #4 aclk = ~aclk;
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task tmo;
		fail_count++;
		print_verdict;
	endtask
	// Ready lines stay high, so response always taken on its first cycle
	task automatic wr(input [15:0] i, input [7:0] d);
		int n;
		n = 0;
		awaddr <= {i, 2'b00};
		wd <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid && n < 200);
		rs = bresp;
		if (n >= 200) tmo;
	endtask
	task automatic rd(input [15:0] i);
		int n;
		n = 0;
		araddr <= {i, 2'b00};
		arvalid <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 0;
		end while (!rvalid && n < 200);
		rv = rdata;
		rs = rresp;
		if (n >= 200) tmo;
	endtask
	task automatic rc(input [15:0] i, input [31:0] e);
		rd(i);
		`CHK(rv, e)
	endtask
	task automatic setup(input [7:0] sel, input [7:0] md);
		wr(`TMR_IDX_MODE, 8'h00);
		wr(`TMR_IDX_CLKSEL, sel);
		wr(`TMR_IDX_MODE, md);
	endtask
	task automatic gap_of(input b);
		int n;
		n = 0;
		do begin @(posedge aclk); n++; end while (!(b ? irq_b : irq_a) && n < 6000);
		if (n >= 6000) tmo;
		gap = 0;
		do begin @(posedge aclk); gap++; end while (!(b ? irq_b : irq_a) && gap < 6000);
		if (gap >= 6000) tmo;
	endtask
	task automatic pulse(input int k);
		repeat (k) begin
			pa <= 1;
			pb <= 1;
			repeat (8) @(posedge aclk);
			pa <= 0;
			pb <= 0;
			repeat (8) @(posedge aclk);
		end
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rc(`TMR_IDX_CLKSEL, 32'h0);
		rc(`TMR_IDX_MODE, 32'h0);
		rc(`TMR_IDX_CNT_A, 32'h0);
		rc(`TMR_IDX_CNT_B, 32'h0);
		rd(16'hff40);
		`CHK(rs, `TMR_RESP_SLVERR)
		wr(16'hff40, 8'h00);
		`CHK(rs, `TMR_RESP_SLVERR)
		wr(`TMR_IDX_CMP_A, 8'hff);
		`CHK(rs, `TMR_RESP_OKAY)
		rc(`TMR_IDX_CMP_A, 32'hff);
		`CHK(rs, `TMR_RESP_OKAY)
		ws <= 4'h0;
		wr(`TMR_IDX_CMP_A, 8'h12);
		ws <= 4'h1;
		rc(`TMR_IDX_CMP_A, 32'hff);
		wr(`TMR_IDX_CLKSEL, 8'h76);
		rc(`TMR_IDX_CLKSEL, 32'h76);
		wr(`TMR_IDX_CNT_A, 8'h55);
		rc(`TMR_IDX_CNT_A, 32'h0);
		wr(`TMR_IDX_BITOP, 8'h09);
		rc(`TMR_IDX_MODE, 32'h2);
		wr(`TMR_IDX_BITOP, 8'h08);
		rc(`TMR_IDX_MODE, 32'h3);
		wr(`TMR_IDX_BITOP, 8'h01);
		rc(`TMR_IDX_MODE, 32'h1);
		$display("test registers finished");
		wr(`TMR_IDX_OSC, 8'h01);
		wr(`TMR_IDX_CMP_A, 8'h02);
		setup(8'h06, 8'h01);
		gap_of(0);
		`CHK(gap, 6)
		wr(`TMR_IDX_OSC, 8'h00);
		gap_of(0);
		`CHK(gap, 12)
		wr(`TMR_IDX_OSC, 8'h01);
		wr(`TMR_IDX_CMP_A, 8'h00);
		for (c = 6; c <= 15; c++) begin
			setup(c[7:0], 8'h01);
			gap_of(0);
			`CHK(gap, 1 << (c == 15 ? 11 : c - 5))
		end
		setup(8'h03, 8'h01);
		repeat (50) @(posedge aclk);
		rc(`TMR_IDX_CNT_A, 32'h0);
		$display("test interval finished");
		wr(`TMR_IDX_CMP_A, 8'hff);
		wr(`TMR_IDX_CMP_B, 8'hff);
		setup(8'h10, 8'h03);
		pulse(3);
		rc(`TMR_IDX_CNT_A, 32'h3);
		rc(`TMR_IDX_CNT_B, 32'h3);
		wr(`TMR_IDX_CMP_B, 8'h01);
		pulse(1);
		rc(`TMR_IDX_CNT_B, 32'h4);
		wr(`TMR_IDX_MODE, 8'h00);
		rc(`TMR_IDX_CNT_B, 32'h0);
		$display("test events finished");
		wr(`TMR_IDX_CMP_A, 8'h01);
		wr(`TMR_IDX_CMP_B, 8'h01);
		setup(8'h06, 8'h05);
		gap_of(1);
		`CHK(gap, 516)
		wr(`TMR_IDX_MODE, 8'h00);
		rc(`TMR_IDX_CNT16, 32'h0);
		wr(`TMR_IDX_CMP_A, 8'hff);
		wr(`TMR_IDX_CMP_B, 8'hff);
		setup(8'h01, 8'h05);
		// 258 rising edges: low byte wraps once into the high byte
		pulse(258);
		rc(`TMR_IDX_CNT16, 32'h102);
		$display("test cascade finished");
		// Reset while running must clear counts and control bytes
		aresetn <= 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rc(`TMR_IDX_CLKSEL, 32'h0);
		rc(`TMR_IDX_MODE, 32'h0);
		rc(`TMR_IDX_CNT16, 32'h0);
		$display("test reset finished");
		print_verdict;
	end
endmodule
